// ---- dv/twc_host.sv ----
// host model that masters the two-wire bus
`timescale 1ns/10ps
module twc_host (
  // timing reference
  input  wire logic core_clk,
  // bus
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaOeN
);
  localparam int QTR = 6;
  logic glitchOn;
  initial begin
    scl = 1'h1;
    sdaOeN = 1'h1;
    glitchOn = 1'h0;
  end
  task automatic waitQ();
    repeat (QTR) @(posedge core_clk);
    #1;
  endtask : waitQ
  // works from idle and as repeated start
  task automatic start();
    sdaOeN = 1'h1;
    waitQ();
    scl = 1'h1;
    waitQ();
    sdaOeN = 1'h0;
    waitQ();
    scl = 1'h0;
    waitQ();
  endtask : start
  task automatic stop();
    sdaOeN = 1'h0;
    waitQ();
    scl = 1'h1;
    waitQ();
    sdaOeN = 1'h1;
    waitQ();
  endtask : stop
  // data set while clock low, held through the high phase
  task automatic bitIo(input logic b, output logic s);
    sdaOeN = b;
    waitQ();
    scl = 1'h1;
    waitQ();
    s = sdaWire;
    waitQ();
    scl = 1'h0;
    if (glitchOn) begin
      #10 scl = 1'h1;
      #8 scl = 1'h0;
    end
    waitQ();
  endtask : bitIo
  // msb first, then the ninth bit in the other direction
  task automatic xferByte(input logic [7:0] tx, input logic ackIn,
                          output logic [7:0] rx, output logic ackOut);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(tx[i], s);
      rx[i] = s;
    end
    bitIo(ackIn, ackOut);
  endtask : xferByte
endmodule : twc_host

// ---- dv/twc_slave_chk.sv ----
// port assertions for the two-wire configuration slave
`timescale 1ns/10ps
module twc_slave_chk (
  // clocks and resets
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       extResetN,
  input wire logic       xtalClk,
  // bus
  input wire logic       sclIn,
  input wire logic       sdaOut,
  input wire logic       sdaOeN,
  // core copies
  input wire logic [7:0] dpllVideoTuning,
  input wire logic [7:0] dcRestoreControl,
  input wire logic       yuvInputMode,
  input wire logic       wideOutputMode
);
  a_drive_level_low: assert property (@(posedge xtalClk) disable iff (reset)
    sdaOut == 1'h0) else $error("data pin driven high");
  a_pull_scl_low: assert property (@(posedge xtalClk)
    disable iff (reset || !extResetN)
    $fell(sdaOeN) |-> !sclIn && $past(sclIn) == 1'h0)
    else $error("pull started while clock high");
  a_release_scl_low: assert property (@(posedge xtalClk)
    disable iff (reset || !extResetN)
    $rose(sdaOeN) |-> !sclIn && $past(sclIn) == 1'h0)
    else $error("release while clock high");
  a_pull_stands: assert property (@(posedge xtalClk)
    disable iff (reset || !extResetN)
    $fell(sdaOeN) |=> !sdaOeN [*8]) else $error("pull too short");
  a_reset_releases: assert property (@(posedge core_clk)
    reset [*4] |-> sdaOeN) else $error("pin not released in reset");
  a_reset_defaults: assert property (@(posedge core_clk) reset [*3] |->
    {dpllVideoTuning, dcRestoreControl, yuvInputMode, wideOutputMode}
    == 18'h00000) else $error("copies not cleared by reset");
  a_pin_defaults: assert property (@(posedge core_clk) !extResetN [*5] |->
    {dpllVideoTuning, dcRestoreControl, yuvInputMode, wideOutputMode}
    == 18'h00000) else $error("copies not cleared by pin");
  a_pin_releases: assert property (@(posedge core_clk)
    !extResetN [*8] |-> sdaOeN) else $error("pin reset kept pull");
endmodule : twc_slave_chk

bind twc_slave twc_slave_chk i_twc_slave_chk (
  .core_clk(core_clk), .reset(reset), .extResetN(extResetN),
  .xtalClk(xtalClk), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
  .dpllVideoTuning(dpllVideoTuning), .dcRestoreControl(dcRestoreControl),
  .yuvInputMode(yuvInputMode), .wideOutputMode(wideOutputMode));

// ---- dv/twc_slave_tb.sv ----
// self-checking bench for the two-wire configuration slave
`timescale 1ns/10ps
module twc_slave_tb;
  logic       core_clk, reset, extResetN, xtalClk, addrStrap;
  logic       scl, hostOeN, sdaWire, sdaOut, sdaOeN;
  logic [7:0] dpllVideoTuning, dcRestoreControl;
  logic       yuvInputMode, wideOutputMode, ack;
  logic [7:0] expReg [64];
  logic [7:0] p;
  integer     seed = 11;
  int         n_mismatch = 0;
  int         checked = 0;
  int         cycles = 0;

  assign sdaWire = (sdaOeN | sdaOut) & hostOeN;
  twc_slave i_twc_slave (.core_clk(core_clk), .reset(reset),
    .extResetN(extResetN), .xtalClk(xtalClk), .addrStrap(addrStrap),
    .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .dpllVideoTuning(dpllVideoTuning), .dcRestoreControl(dcRestoreControl),
    .yuvInputMode(yuvInputMode), .wideOutputMode(wideOutputMode));
  twc_host i_twc_host (.core_clk(core_clk), .sdaWire(sdaWire), .scl(scl),
    .sdaOeN(hostOeN));

  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    xtalClk = 1'h0;
    #3;
    forever #6 xtalClk = ~xtalClk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] expRd(input logic [7:0] a);
    return (a < 8'h40) ? expReg[a[5:0]] : 8'h00;
  endfunction : expRd
  task automatic checkCopies();
    check("dpll copy", dpllVideoTuning, expReg[6'h1C]);
    check("restore copy", dcRestoreControl, expReg[6'h23]);
    check("yuv mode", {7'h00, yuvInputMode}, {7'h00, expReg[6'h05][2]});
    check("wide mode", {7'h00, wideOutputMode},
          {7'h00, expReg[6'h18][0]});
  endtask : checkCopies
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input int n, input logic useV, input logic [7:0] v,
                    output logic devAck);
    logic [7:0] rx, d;
    logic a;
    i_twc_host.start();
    i_twc_host.xferByte({dev, twc_pkg::DIR_WRITE}, 1'h1, rx, devAck);
    i_twc_host.xferByte(ptr, 1'h1, rx, a);
    for (int i = 0; i < n; i++) begin
      d = (i == 0 && useV) ? v : 8'($random(seed));
      i_twc_host.xferByte(d, 1'h1, rx, a);
      if (devAck === 1'h0 && ptr < 8'h40) expReg[ptr[5:0]] = d;
      ptr = ptr + 8'h01;
    end
    i_twc_host.stop();
  endtask : wr
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                    input int n);
    logic [7:0] rx;
    logic a;
    i_twc_host.start();
    i_twc_host.xferByte({dev, twc_pkg::DIR_WRITE}, 1'h1, rx, a);
    i_twc_host.xferByte(ptr, 1'h1, rx, a);
    i_twc_host.start();
    i_twc_host.xferByte({dev, twc_pkg::DIR_READ}, 1'h1, rx, a);
    check("read addr ack", {7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      i_twc_host.xferByte(8'hFF, (i == n - 1), rx, a);
      check("read data", rx, expRd(ptr));
      ptr = ptr + 8'h01;
    end
    i_twc_host.stop();
  endtask : rd

  initial begin
    reset = 1'h1;
    extResetN = 1'h1;
    addrStrap = 1'h0;
    foreach (expReg[i]) expReg[i] = 8'h00;
    repeat (8) @(posedge core_clk);
    #1 reset = 1'h0;
    repeat (20) @(posedge core_clk);
    #1;
    checkCopies();
    rd(7'h4C, 8'h00, 4);
    $display("test done: defaults");
    wr(7'h4C, 8'h1C, 3, 1'h1, 8'h49, ack);
    wr(7'h4C, 8'h23, 1, 1'h1, 8'h78, ack);
    wr(7'h4C, 8'h05, 1, 1'h0, 8'h00, ack);
    wr(7'h4C, 8'h18, 1, 1'h0, 8'h00, ack);
    checkCopies();
    rd(7'h4C, 8'h1B, 6);
    rd(7'h4C, 8'h3E, 4);
    $display("test done: recommended writes");
    for (int k = 0; k < 4; k++) begin
      p = 8'($random(seed)) & 8'h3F;
      wr(7'h4C, p, 1 + k, 1'h0, 8'h00, ack);
      rd(7'h4C, p, 1 + k);
    end
    $display("test done: random bursts");
    for (int s = 0; s < 2; s++) begin
      addrStrap = s[0];
      repeat (10) @(posedge core_clk);
      #1;
      for (int d = 0; d < 2; d++) begin
        wr(7'h4C | 7'(d), 8'h10, 1, 1'h0, 8'h00, ack);
        check("strap ack", {7'h00, ack}, {7'h00, d != s});
      end
      rd(7'h4C | 7'(s), 8'h10, 1);
    end
    #1 addrStrap = 1'h0;
    $display("test done: strap address");
    i_twc_host.xferByte({7'h4C, twc_pkg::DIR_WRITE}, 1'h1, p, ack);
    check("no start ack", {7'h00, ack}, 8'h01);
    i_twc_host.stop();
    $display("test done: no start");
    i_twc_host.glitchOn = 1'h1;
    wr(7'h4C, 8'h30, 2, 1'h0, 8'h00, ack);
    i_twc_host.glitchOn = 1'h0;
    rd(7'h4C, 8'h30, 2);
    $display("test done: clock glitch");
    extResetN = 1'h0;
    repeat (10) @(posedge core_clk);
    #1 extResetN = 1'h1;
    foreach (expReg[i]) expReg[i] = 8'h00;
    repeat (20) @(posedge core_clk);
    #1;
    checkCopies();
    rd(7'h4C, 8'h1C, 8);
    $display("test done: pin reset");
    wrap_up();
  end
endmodule : twc_slave_tb

// ---- verilog/twc_line_filter.sv ----
// two-flop synchroniser followed by a glitch filter on one bus line
`timescale 1ns/10ps
module twc_line_filter (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // line
  input  wire logic rawIn,
  output logic      filtOut
);

  logic                             syncA;
  logic                             syncB;
  logic [twc_pkg::FILTER_TAPS-1:0]  hist;
  logic [twc_pkg::FILTER_TAPS-1:0]  next_hist;
  logic                             next_filtOut;

  always_comb begin
    next_hist    = {hist[twc_pkg::FILTER_TAPS-2:0], syncB};
    next_filtOut = filtOut;
    // output follows only after the line held one level for all taps
    if (&hist) begin
      next_filtOut = 1'h1;
    end else if (~|hist) begin
      next_filtOut = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    syncA <= rawIn;
    syncB <= syncA;
    if (rst) begin
      hist    <= '1;
      filtOut <= 1'h1;
    end else begin
      hist    <= next_hist;
      filtOut <= next_filtOut;
    end
  end

endmodule : twc_line_filter

// ---- verilog/twc_pkg.sv ----
// constants and types shared by the two-wire configuration slave
package twc_pkg;

  // bus address: upper six bits fixed, lowest bit from the strap pin
  localparam logic [5:0] ADDR_UPPER   = 6'h26;
  localparam logic [6:0] ADDR_STRAP_0 = 7'h4C;
  localparam logic [6:0] ADDR_STRAP_1 = 7'h4D;

  // direction bit values
  localparam logic       DIR_WRITE    = 1'h0;
  localparam logic       DIR_READ     = 1'h1;

  // deglitch depth in crystal clock periods
  localparam int         FILTER_TAPS  = 3;

  // configuration register file
  localparam int         REG_AW       = 6;
  localparam int         REG_COUNT    = 64;
  localparam logic [7:0] REG_RESET    = 8'h00;

  // register offsets
  localparam logic [7:0] OFS_INPUT_CFG   = 8'h05;
  localparam logic [7:0] OFS_OUTPUT_CFG  = 8'h18;
  localparam logic [7:0] OFS_DPLL_VIDEO  = 8'h1C;
  localparam logic [7:0] OFS_DC_RESTORE  = 8'h23;

  // field positions; zero selects RGB input and 24-bit output
  localparam int         BIT_YUV_INPUT   = 2;
  localparam int         BIT_WIDE_OUTPUT = 0;

  // serial engine states
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_PTR       = 9'h008,
    ST_PTR_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } twc_state_t;

endpackage : twc_pkg

// ---- verilog/twc_slave.sv ----
// two-wire configuration slave with register file and core-side copies
//
// Functional notes
// - Host drives clock; data line is open drain, shared by all.
// - Address upper six bits are 100110, lowest bit follows strap.
// - Address is 0x4C with strap low, 0x4D with strap high.
// - Device ignores the bus until it sees a start condition.
// - Device acknowledges when the address matches its own.
// - Stop or new start ends transfer and current direction.
// - Transmitter holds data stable while clock is high.
// - Clock is deglitched over three taps and delayed six crystal periods.
// - Write data sampled on the delayed rising clock edge.
// - Read data changes after the delayed falling clock edge.
// - Pointer increments after each written data byte.
// - Pointer increments after each read byte returned.
// - Power-on reset returns all registers to defaults.
// - External reset pin does the same; may be tied high.
// - Defaults select AC-coupled RGB, first input, 24-bit output.
`timescale 1ns/10ps
module twc_slave (
  // core clock and power-on reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // external reset pin, active low
  input  wire logic       extResetN,
  // crystal reference clock for the serial logic
  input  wire logic       xtalClk,
  // address strap pin
  input  wire logic       addrStrap,
  // serial clock pin, input only
  input  wire logic       sclIn,
  // serial data pin
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOeN,
  // configuration seen by the core
  output logic [7:0]      dpllVideoTuning,
  output logic [7:0]      dcRestoreControl,
  output logic            yuvInputMode,
  output logic            wideOutputMode
);

  // ---------------------------------------------------------------
  // core domain: reset merge
  // ---------------------------------------------------------------
  logic [1:0]  extSync;
  logic        coreRst;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      extSync <= 2'h3;
    end else begin
      extSync <= {extSync[0], extResetN};
    end
  end

  always_ff @(posedge core_clk) begin
    coreRst <= reset | ~extSync[1];
  end

  // ---------------------------------------------------------------
  // crystal domain: reset and strap synchronisers
  // ---------------------------------------------------------------
  logic [1:0]  rstSync;
  logic        xtalRst;
  logic [1:0]  strapSync;
  logic [6:0]  devAddr;

  always_ff @(posedge xtalClk) begin
    rstSync   <= {rstSync[0], coreRst};
    strapSync <= {strapSync[0], addrStrap};
  end

  assign xtalRst = rstSync[1];
  assign devAddr = {twc_pkg::ADDR_UPPER, strapSync[1]};

  // ---------------------------------------------------------------
  // line filters
  // ---------------------------------------------------------------
  logic sclF;
  logic sdaF;

  // data goes through the same path so both lines stay aligned
  twc_line_filter u_scl_filter (
    .clk     (xtalClk),
    .rst     (xtalRst),
    .rawIn   (sclIn),
    .filtOut (sclF)
  );

  twc_line_filter u_sda_filter (
    .clk     (xtalClk),
    .rst     (xtalRst),
    .rawIn   (sdaIn),
    .filtOut (sdaF)
  );

  // ---------------------------------------------------------------
  // bus event detection
  // ---------------------------------------------------------------
  logic sclPrev;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  always_ff @(posedge xtalClk) begin
    if (xtalRst) begin
      sclPrev <= 1'h1;
      sdaPrev <= 1'h1;
    end else begin
      sclPrev <= sclF;
      sdaPrev <= sdaF;
    end
  end

  assign sclRise   = sclF & ~sclPrev;
  assign sclFall   = ~sclF & sclPrev;
  assign startSeen = sclF & sclPrev & sdaPrev & ~sdaF;
  assign stopSeen  = sclF & sclPrev & ~sdaPrev & sdaF;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0]  regFile [twc_pkg::REG_COUNT];

  function automatic logic regInRange(input logic [7:0] addr);
    regInRange = (32'(addr) < twc_pkg::REG_COUNT);
  endfunction : regInRange

  // ---------------------------------------------------------------
  // serial engine
  // ---------------------------------------------------------------
  twc_pkg::twc_state_t state;
  twc_pkg::twc_state_t next_state;
  logic [7:0]  shiftReg;
  logic [7:0]  next_shiftReg;
  logic [2:0]  bitCnt;
  logic [2:0]  next_bitCnt;
  logic        byteFull;
  logic        next_byteFull;
  logic [7:0]  ptr;
  logic [7:0]  next_ptr;
  logic        hostAck;
  logic        next_hostAck;
  logic        next_sdaOeN;
  logic        wrToggle;
  logic        next_wrToggle;
  logic        wrEn;
  logic [7:0]  rdByte;

  assign rdByte = regInRange(ptr) ? regFile[ptr[twc_pkg::REG_AW-1:0]]
                                  : twc_pkg::REG_RESET;

  always_comb begin
    next_state    = state;
    next_shiftReg = shiftReg;
    next_bitCnt   = bitCnt;
    next_byteFull = byteFull;
    next_ptr      = ptr;
    next_hostAck  = hostAck;
    next_sdaOeN   = sdaOeN;
    next_wrToggle = wrToggle;
    wrEn          = 1'h0;
    if (stopSeen) begin
      next_state  = twc_pkg::ST_IDLE;
      next_sdaOeN = 1'h1;
    end else if (startSeen) begin
      // a start also serves as the repeated start
      next_state    = twc_pkg::ST_ADDR;
      next_bitCnt   = 3'h0;
      next_byteFull = 1'h0;
      next_sdaOeN   = 1'h1;
    end else begin
      unique case (state)
        twc_pkg::ST_IDLE: begin
          next_sdaOeN = 1'h1;
        end
        twc_pkg::ST_ADDR, twc_pkg::ST_PTR, twc_pkg::ST_WDATA: begin
          if (sclRise && !byteFull) begin
            next_shiftReg = {shiftReg[6:0], sdaF};
            next_bitCnt   = bitCnt + 3'h1;
            next_byteFull = (bitCnt == 3'h7);
          end
          if (sclFall && byteFull) begin
            next_byteFull = 1'h0;
            next_sdaOeN   = 1'h0;
            if (state == twc_pkg::ST_ADDR) begin
              if (shiftReg[7:1] == devAddr) begin
                next_state   = twc_pkg::ST_ADDR_ACK;
                next_hostAck = shiftReg[0];
              end else begin
                next_state  = twc_pkg::ST_IDLE;
                next_sdaOeN = 1'h1;
              end
            end else if (state == twc_pkg::ST_PTR) begin
              next_ptr   = shiftReg;
              next_state = twc_pkg::ST_PTR_ACK;
            end else begin
              wrEn          = 1'h1;
              next_wrToggle = ~wrToggle;
              next_ptr      = ptr + 8'h01;
              next_state    = twc_pkg::ST_WDATA_ACK;
            end
          end
        end
        twc_pkg::ST_ADDR_ACK: begin
          if (sclFall) begin
            next_bitCnt = 3'h0;
            if (hostAck == twc_pkg::DIR_READ) begin
              next_shiftReg = rdByte;
              next_sdaOeN   = rdByte[7];
              next_state    = twc_pkg::ST_RDATA;
            end else begin
              next_sdaOeN = 1'h1;
              next_state  = twc_pkg::ST_PTR;
            end
          end
        end
        twc_pkg::ST_PTR_ACK: begin
          if (sclFall) begin
            next_sdaOeN = 1'h1;
            next_bitCnt = 3'h0;
            next_state  = twc_pkg::ST_WDATA;
          end
        end
        twc_pkg::ST_WDATA_ACK: begin
          if (sclFall) begin
            next_sdaOeN = 1'h1;
            next_bitCnt = 3'h0;
            next_state  = twc_pkg::ST_WDATA;
          end
        end
        twc_pkg::ST_RDATA: begin
          if (sclRise && !byteFull) begin
            next_bitCnt   = bitCnt + 3'h1;
            next_byteFull = (bitCnt == 3'h7);
          end
          if (sclFall) begin
            if (byteFull) begin
              next_byteFull = 1'h0;
              next_sdaOeN   = 1'h1;
              next_ptr      = ptr + 8'h01;
              next_state    = twc_pkg::ST_RDATA_ACK;
            end else begin
              next_shiftReg = {shiftReg[6:0], 1'h0};
              next_sdaOeN   = shiftReg[6];
            end
          end
        end
        twc_pkg::ST_RDATA_ACK: begin
          if (sclRise) begin
            next_hostAck = ~sdaF;
          end
          if (sclFall) begin
            next_bitCnt = 3'h0;
            if (hostAck) begin
              next_shiftReg = rdByte;
              next_sdaOeN   = rdByte[7];
              next_state    = twc_pkg::ST_RDATA;
            end else begin
              // last byte refused by host: wait for stop or start
              next_state = twc_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_state  = twc_pkg::ST_IDLE;
          next_sdaOeN = 1'h1;
        end
      endcase
    end
  end

  always_ff @(posedge xtalClk) begin
    if (xtalRst) begin
      state    <= twc_pkg::ST_IDLE;
      shiftReg <= 8'h00;
      bitCnt   <= 3'h0;
      byteFull <= 1'h0;
      ptr      <= 8'h00;
      hostAck  <= 1'h0;
      sdaOeN   <= 1'h1;
      wrToggle <= 1'h0;
    end else begin
      state    <= next_state;
      shiftReg <= next_shiftReg;
      bitCnt   <= next_bitCnt;
      byteFull <= next_byteFull;
      ptr      <= next_ptr;
      hostAck  <= next_hostAck;
      sdaOeN   <= next_sdaOeN;
      wrToggle <= next_wrToggle;
    end
  end

  // pin is only ever pulled low; release lets the pull-up win
  always_ff @(posedge xtalClk) begin
    sdaOut <= 1'h0;
  end

  always_ff @(posedge xtalClk) begin
    if (xtalRst) begin
      for (int i = 0; i < twc_pkg::REG_COUNT; i++) begin
        regFile[i] <= twc_pkg::REG_RESET;
      end
    end else if (wrEn && regInRange(ptr)) begin
      regFile[ptr[twc_pkg::REG_AW-1:0]] <= shiftReg;
    end
  end

  // ---------------------------------------------------------------
  // core domain: copy configuration after each serial write
  // ---------------------------------------------------------------
  logic [1:0]  tgSync;
  logic        tgSeen;
  logic        tgChange;
  logic [7:0]  next_dpllVideoTuning;
  logic [7:0]  next_dcRestoreControl;
  logic        next_yuvInputMode;
  logic        next_wideOutputMode;

  always_ff @(posedge core_clk) begin
    tgSync <= {tgSync[0], wrToggle};
  end

  assign tgChange = tgSync[1] ^ tgSeen;

  // file entries are stable long before the toggle is seen here
  always_comb begin
    next_dpllVideoTuning  = dpllVideoTuning;
    next_dcRestoreControl = dcRestoreControl;
    next_yuvInputMode     = yuvInputMode;
    next_wideOutputMode   = wideOutputMode;
    if (tgChange) begin
      next_dpllVideoTuning  = regFile[twc_pkg::OFS_DPLL_VIDEO[5:0]];
      next_dcRestoreControl = regFile[twc_pkg::OFS_DC_RESTORE[5:0]];
      next_yuvInputMode     =
        regFile[twc_pkg::OFS_INPUT_CFG[5:0]][twc_pkg::BIT_YUV_INPUT];
      next_wideOutputMode   =
        regFile[twc_pkg::OFS_OUTPUT_CFG[5:0]][twc_pkg::BIT_WIDE_OUTPUT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      tgSeen           <= tgSync[1];
      dpllVideoTuning  <= twc_pkg::REG_RESET;
      dcRestoreControl <= twc_pkg::REG_RESET;
      yuvInputMode     <= 1'h0;
      wideOutputMode   <= 1'h0;
    end else begin
      tgSeen           <= tgSync[1];
      dpllVideoTuning  <= next_dpllVideoTuning;
      dcRestoreControl <= next_dcRestoreControl;
      yuvInputMode     <= next_yuvInputMode;
      wideOutputMode   <= next_wideOutputMode;
    end
  end

endmodule : twc_slave
